// >>> power_monitor_pkg.sv
// shared constants and types for the power monitor result path
package power_monitor_pkg;
  // ==========================================================================
  // timing
  localparam int          CLK_FREQ_HZ      = 25_000_000;
  localparam int          CONV_TIME_MIN_US = 50;
  localparam int          CONV_CYCLES      = CONV_TIME_MIN_US * (CLK_FREQ_HZ / 1_000_000);
  localparam logic [10:0] CONV_LAST        = 11'(CONV_CYCLES - 1);
  // ==========================================================================
  // register offsets
  localparam logic [3:0]  REG_CONFIG     = 4'h0;
  localparam logic [3:0]  REG_SHUNT_CAL  = 4'h1;
  localparam logic [3:0]  REG_SHUNT_VOLT = 4'h2;
  localparam logic [3:0]  REG_BUS_VOLT   = 4'h3;
  localparam logic [3:0]  REG_DIE_TEMP   = 4'h4;
  localparam logic [3:0]  REG_CURRENT    = 4'h5;
  localparam logic [3:0]  REG_POWER      = 4'h6;
  localparam logic [3:0]  REG_STATUS     = 4'h7;
  // ==========================================================================
  // fields and reset values
  localparam int          CFG_RANGE_BIT    = 0;
  localparam int          CFG_AVG_LSB      = 1;
  localparam int          CFG_AVG_MSB      = 3;
  localparam int          CFG_ENABLE_BIT   = 4;
  localparam int          CFG_WIDTH        = 5;
  localparam logic [4:0]  CONFIG_RESET     = 5'h10;
  localparam logic [15:0] SHUNT_CAL_RESET  = 16'h0000;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;
  localparam logic [23:0] POWER_RESET      = 24'h000000;
  localparam int          STATUS_READY_BIT = 0;
  // ==========================================================================
  // arithmetic
  localparam int          DATA_W        = 24;
  localparam int          CURRENT_SHIFT = 11;
  localparam int          POWER_SHIFT   = 6;
  localparam logic [15:0] BUS_MAX       = 16'h7FFF;
  localparam int          TEMP_WIDTH    = 12;
  localparam int          TEMP_LSB      = 4;
  localparam int          CALC_LATENCY  = 3;

  typedef enum logic [1:0] {CH_SHUNT, CH_BUS, CH_TEMP} channel_type;

  typedef struct packed {
    logic signed [15:0] current;
    logic [23:0]        power;
  } calc_result_type;

  // averaging select to shift: 1,4,16,64,128,256,512,1024 samples
  function automatic logic [3:0] avg_shift(input logic [2:0] sel);
    case (sel)
      3'h0:    avg_shift = 4'h0;
      3'h1:    avg_shift = 4'h2;
      3'h2:    avg_shift = 4'h4;
      3'h3:    avg_shift = 4'h6;
      3'h4:    avg_shift = 4'h7;
      3'h5:    avg_shift = 4'h8;
      3'h6:    avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction
endpackage

// >>> result_averager.sv
// running sample averager for one measurement channel
`timescale 1ns/100ps
module result_averager
  import power_monitor_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // samples in
  input  wire logic               restart,
  input  wire logic [2:0]         avg_sel,
  input  wire logic               sample_valid,
  input  wire logic signed [15:0] sample,
  // mean out
  output logic                    result_valid,
  output logic signed [15:0]      result
);
  typedef struct packed {
    logic signed [26:0] acc;
    logic [9:0]         count;
    logic               valid;
    logic signed [15:0] result;
  } avg_state_type;

  avg_state_type state;
  avg_state_type next_state;
  logic [3:0]    shift;
  logic [9:0]    last;
  logic signed [26:0] sum;

  always_comb begin
    shift      = avg_shift(avg_sel);
    last       = 10'((11'h001 << shift) - 11'h001);
    sum        = state.acc + 27'(sample);
    next_state = state;
    next_state.valid = 1'b0;
    if (restart) begin
      next_state.acc   = '0;
      next_state.count = '0;
    end else if (sample_valid) begin
      if (state.count == last) begin
        next_state.result = 16'(sum >>> shift);
        next_state.valid  = 1'b1;
        next_state.acc    = '0;
        next_state.count  = '0;
      end else begin
        next_state.acc   = sum;
        next_state.count = state.count + 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign result_valid = state.valid;
  assign result       = state.result;

  AST_AVG_COUNT: assert property (@(posedge clk) disable iff (!resetn)
    state.valid |-> $past(state.count) == $past(last) && $past(sample_valid))
    else $error("average released before its sample count");
endmodule

// >>> current_power_calc.sv
// current and power calculation pipeline
`timescale 1ns/100ps
module current_power_calc
  import power_monitor_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // operands
  input  wire logic               start,
  input  wire logic signed [15:0] shunt_code,
  input  wire logic [15:0]        bus_code,
  input  wire logic [15:0]        cal,
  // results
  output logic                    done,
  output calc_result_type         result
);
  typedef struct packed {
    logic [2:0]         stage;
    logic signed [32:0] product;
    logic               cal_zero;
    logic signed [15:0] shunt_hold;
    logic signed [15:0] current;
    logic [23:0]        power;
  } calc_state_type;

  calc_state_type     state;
  calc_state_type     next_state;
  logic signed [32:0] scaled;
  logic [15:0]        magnitude;
  logic [31:0]        watts;

  always_comb begin
    next_state       = state;
    next_state.stage = {state.stage[1:0], start};
    scaled           = state.product >>> CURRENT_SHIFT;
    magnitude        = state.current[15] ? 16'(-state.current) : 16'(state.current);
    watts            = (32'(magnitude) * 32'(bus_code)) >> POWER_SHIFT;
    if (start) begin
      next_state.product    = 33'(shunt_code) * $signed({17'h00000, cal});
      next_state.cal_zero   = (cal == 16'h0000);
      next_state.shunt_hold = shunt_code;
    end
    if (state.stage[0]) begin
      if (state.cal_zero) begin
        next_state.current = 16'sh0000;
      end else if (scaled > 33'sh000007FFF) begin
        next_state.current = 16'sh7FFF;
      end else if (scaled < -33'sh000008000) begin
        next_state.current = -16'sh8000;
      end else begin
        next_state.current = 16'(scaled);
      end
    end
    if (state.stage[1]) begin
      next_state.power = (watts > 32'h00FFFFFF) ? 24'hFFFFFF : watts[23:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done           = state.stage[2];
  assign result.current = state.current;
  assign result.power   = state.power;

  AST_ZERO_CAL: assert property (@(posedge clk) disable iff (!resetn)
    done && state.cal_zero |-> state.current == 16'sh0000 && state.power == 24'h000000)
    else $error("zero calibration gave a nonzero result");
  AST_CURRENT_SIGN: assert property (@(posedge clk) disable iff (!resetn)
    done && state.shunt_hold < 0 |-> state.current <= 0)
    else $error("reverse shunt voltage gave positive current");
endmodule

// >>> power_monitor_result_scaling.sv
// result registers, sequencing and scaling of the power monitor
`timescale 1ns/100ps

// Overview of operation
// - one range bit picks the 163.84 mV shunt span when clear and the 40.96 mV span when set.
// - shunt codes weigh 5 uV in the wide range and 1.25 uV in the narrow range.
// - shunt and bus results are 16 bits, the shunt result signed.
// - the bus result is non-negative at 3.125 mV per code.
// - the die temperature is a signed 12-bit value at 125 mdegC per code.
// - the temperature code spans -256 to +255.875 degC.
// - a new current is computed after each shunt result from the calibration value.
// - a zero calibration value yields a zero current.
// - power is a 24-bit code worth 0.2 times the current step watts per code.
// - the fastest conversion period is 50 us.
// - successive conversions are averaged over a selectable sample count.
// - the temperature sits in bits 15 to 4 of its word.
module power_monitor_result_scaling
  import power_monitor_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0]      reg_rdata,
  // converter side
  output logic                   adc_start,
  output channel_type            adc_channel,
  output logic                   shunt_range_select,
  input  wire logic              adc_done,
  input  wire logic [15:0]       adc_data
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic [CFG_WIDTH-1:0] config_bits;
    logic [15:0]          shunt_cal;
    logic [15:0]          shunt_voltage_result;
    logic [15:0]          bus_voltage_result;
    logic [15:0]          die_temperature_result;
    logic [15:0]          current_result;
    logic [23:0]          power_result;
    logic                 ready;
    logic [DATA_W-1:0]    rdata;
    logic [10:0]          timer;
    channel_type          channel;
    logic                 adc_start;
    logic                 calc_start;
  } top_state_type;

  top_state_type   state;
  top_state_type   next_state;

  // ==========================================================================
  // averagers, one per channel
  logic [2:0]        avg_valid;
  logic signed [15:0] avg_result [3];
  logic signed [15:0] avg_sample [3];
  logic              cfg_write;

  assign cfg_write = reg_wr && (reg_addr == REG_CONFIG);

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_avg
      if (i == CH_TEMP) begin : g_temp
        // 12-bit signed code widened for the sum
        assign avg_sample[i] = {{(16-TEMP_WIDTH){adc_data[TEMP_WIDTH-1]}}, adc_data[TEMP_WIDTH-1:0]};
      end else if (i == CH_BUS) begin : g_bus
        // bus reading never goes negative
        assign avg_sample[i] = adc_data[15] ? BUS_MAX : adc_data;
      end else begin : g_shunt
        assign avg_sample[i] = adc_data;
      end
      result_averager u_avg (
        .clk          (clk),
        .resetn       (resetn),
        .restart      (cfg_write),
        .avg_sel      (state.config_bits[CFG_AVG_MSB:CFG_AVG_LSB]),
        .sample_valid (adc_done && (state.channel == channel_type'(i))),
        .sample       (avg_sample[i]),
        .result_valid (avg_valid[i]),
        .result       (avg_result[i])
      );
    end
  endgenerate

  // ==========================================================================
  // current and power
  logic            calc_done;
  calc_result_type calc_result;

  current_power_calc u_calc (
    .clk        (clk),
    .resetn     (resetn),
    .start      (state.calc_start),
    .shunt_code (state.shunt_voltage_result),
    .bus_code   (state.bus_voltage_result),
    .cal        (state.shunt_cal),
    .done       (calc_done),
    .result     (calc_result)
  );

  // ==========================================================================
  // read decode
  function automatic logic [DATA_W-1:0] read_mux(input top_state_type s, input logic [3:0] addr);
    case (addr)
      REG_CONFIG:     read_mux = DATA_W'(s.config_bits);
      REG_SHUNT_CAL:  read_mux = DATA_W'(s.shunt_cal);
      REG_SHUNT_VOLT: read_mux = DATA_W'(s.shunt_voltage_result);
      REG_BUS_VOLT:   read_mux = DATA_W'(s.bus_voltage_result);
      REG_DIE_TEMP:   read_mux = DATA_W'(s.die_temperature_result);
      REG_CURRENT:    read_mux = DATA_W'(s.current_result);
      REG_POWER:      read_mux = s.power_result;
      REG_STATUS:     read_mux = DATA_W'(s.ready) << STATUS_READY_BIT;
      default:        read_mux = '0;
    endcase
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    next_state            = state;
    next_state.adc_start  = 1'b0;
    next_state.calc_start = 1'b0;

    // conversion pacing, fastest period
    if (!state.config_bits[CFG_ENABLE_BIT]) begin
      next_state.timer = '0;
    end else if (state.timer == CONV_LAST) begin
      next_state.timer     = '0;
      next_state.adc_start = 1'b1;
      case (state.channel)
        CH_SHUNT: next_state.channel = CH_BUS;
        CH_BUS:   next_state.channel = CH_TEMP;
        CH_TEMP:  next_state.channel = CH_SHUNT;
        default:  next_state.channel = CH_SHUNT;
      endcase
    end else begin
      next_state.timer = state.timer + 11'h001;
    end

    // averaged results into result words
    if (avg_valid[CH_SHUNT]) begin
      next_state.shunt_voltage_result = avg_result[CH_SHUNT];
      next_state.calc_start           = 1'b1;
    end
    if (avg_valid[CH_BUS]) begin
      next_state.bus_voltage_result = {1'b0, avg_result[CH_BUS][14:0]};
    end
    if (avg_valid[CH_TEMP]) begin
      next_state.die_temperature_result = {avg_result[CH_TEMP][TEMP_WIDTH-1:0], {TEMP_LSB{1'b0}}};
    end

    // software writes
    if (cfg_write) begin
      next_state.config_bits = reg_wdata[CFG_WIDTH-1:0];
    end
    if (reg_wr && (reg_addr == REG_SHUNT_CAL)) begin
      next_state.shunt_cal = reg_wdata[15:0];
    end

    // reads answer in the next cycle only
    next_state.rdata = reg_rd ? read_mux(state, reg_addr) : '0;
    if (reg_rd && (reg_addr == REG_STATUS)) begin
      next_state.ready = 1'b0;
    end

    // new calculation beats a status clear
    if (calc_done) begin
      next_state.current_result = calc_result.current;
      next_state.power_result   = calc_result.power;
      next_state.ready          = 1'b1;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state                        <= '0;
      state.config_bits            <= CONFIG_RESET;
      state.shunt_cal              <= SHUNT_CAL_RESET;
      state.shunt_voltage_result   <= RESULT_RESET;
      state.bus_voltage_result     <= RESULT_RESET;
      state.die_temperature_result <= RESULT_RESET;
      state.current_result         <= RESULT_RESET;
      state.power_result           <= POWER_RESET;
      state.channel                <= CH_TEMP;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata          = state.rdata;
  assign adc_start          = state.adc_start;
  assign adc_channel        = state.channel;
  assign shunt_range_select = state.config_bits[CFG_RANGE_BIT];

  // ==========================================================================
  // checks
  localparam int CALC_MIN = 3;
  localparam int CALC_MAX = 4;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_RANGE_BIT: assert property (
    cfg_write |=> shunt_range_select == $past(reg_wdata[CFG_RANGE_BIT]))
    else $error("range select does not follow the config write");

  AST_SHUNT_RESULT: assert property (
    avg_valid[CH_SHUNT] |=> state.shunt_voltage_result == $past(avg_result[CH_SHUNT]))
    else $error("shunt result differs from the averaged code");

  AST_SHUNT_READ: assert property (
    reg_rd && reg_addr == REG_SHUNT_VOLT && !avg_valid[CH_SHUNT]
      |=> reg_rdata == {8'h00, $past(state.shunt_voltage_result)} ##1 reg_rdata == 24'h000000 || $past(reg_rd))
    else $error("shunt read data wrong or held too long");

  AST_BUS_POSITIVE: assert property (
    avg_valid[CH_BUS] |=> state.bus_voltage_result == $past(avg_result[CH_BUS]) && !state.bus_voltage_result[15])
    else $error("bus result went negative or lost its code");

  AST_TEMP_FIELD: assert property (
    avg_valid[CH_TEMP] |=> state.die_temperature_result[15:4] == $past(avg_result[CH_TEMP][11:0]))
    else $error("temperature code misplaced");

  AST_TEMP_LOW_ZERO: assert property (
    state.die_temperature_result[3:0] == 4'h0)
    else $error("temperature low bits not zero");

  AST_TEMP_SPAN: assert property (
    avg_valid[CH_TEMP] |=> $signed(state.die_temperature_result)
      == $signed($past(avg_result[CH_TEMP][11:0])) * 32'sh10)
    else $error("temperature code outside its span");

  AST_CURRENT_FOLLOWS: assert property (
    avg_valid[CH_SHUNT] |=> state.calc_start ##[CALC_MIN:CALC_MAX] state.ready)
    else $error("no current after a shunt result");

  AST_PACE: assert property (
    adc_start |-> $past(state.timer) == CONV_LAST)
    else $error("conversion started early");

  AST_POWER_LOAD: assert property (
    calc_done |=> state.power_result == $past(calc_result.power) && state.ready)
    else $error("power result not loaded");

  COV_SHUNT_CALC: cover property (avg_valid[CH_SHUNT] ##[1:5] calc_done);
  COV_TEMP: cover property (avg_valid[CH_TEMP]);
  COV_STATUS_CLEAR: cover property (state.ready && reg_rd && reg_addr == REG_STATUS);
  COV_NARROW: cover property (shunt_range_select && adc_start);
endmodule

// >>> converter_model.sv
// behavioural converter answering the monitor's conversion requests
`timescale 1ns/100ps
module converter_model
  import power_monitor_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // conversion request
  input  wire logic        adc_start,
  input  wire channel_type adc_channel,
  // scenario controls
  input  wire logic        slow,
  input  wire logic [15:0] delta,
  input  wire logic [15:0] shunt_base,
  input  wire logic [15:0] bus_base,
  input  wire logic [15:0] temp_base,
  // conversion result
  output logic             adc_done,
  output logic [15:0]      adc_data
);
  logic        busy;
  logic [9:0]  wait_cnt;
  channel_type chan;
  logic [2:0]  flip;
  logic [15:0] base;

  always_comb begin
    case (chan)
      CH_SHUNT: base = shunt_base;
      CH_BUS:   base = bus_base;
      default:  base = temp_base;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy     <= 1'h0;
      wait_cnt <= 10'h000;
      chan     <= CH_SHUNT;
      flip     <= 3'h0;
      adc_done <= 1'h0;
      adc_data <= 16'h5A5A;
    end else begin
      adc_done <= 1'h0;
      // no result on the lines: keep them toggling
      adc_data <= ~adc_data;
      if (adc_start) begin
        busy     <= 1'h1;
        chan     <= adc_channel;
        wait_cnt <= slow ? 10'h3E7 : 10'h001;
      end else if (busy) begin
        if (wait_cnt == 10'h000) begin
          busy       <= 1'h0;
          adc_done   <= 1'h1;
          // samples alternate around the base so a mean is exact
          adc_data   <= flip[chan] ? base + delta : base - delta;
          flip[chan] <= ~flip[chan];
        end else begin
          wait_cnt <= wait_cnt - 10'h001;
        end
      end
    end
  end
endmodule

// >>> tb.sv
// self-checking testbench for the power monitor result path
`timescale 1ns/100ps
module tb
  import power_monitor_pkg::*;
;
  logic              clk        = 1'h0;
  logic              resetn     = 1'h0;
  logic              reg_wr     = 1'h0;
  logic              reg_rd     = 1'h0;
  logic [3:0]        reg_addr   = 4'h0;
  logic [DATA_W-1:0] reg_wdata  = 24'h000000;
  logic [DATA_W-1:0] reg_rdata;
  logic              adc_start;
  channel_type       adc_channel;
  logic              shunt_range_select;
  logic              adc_done;
  logic [15:0]       adc_data;
  logic              slow       = 1'h0;
  logic [15:0]       delta      = 16'h0000;
  logic [15:0]       shunt_base = 16'h0000;
  logic [15:0]       bus_base   = 16'h0000;
  logic [15:0]       temp_base  = 16'h0000;
  int                n_fail     = 0;
  int                num_checks = 0;
  int                cyc        = 0;
  int                since      = 0;
  int                n_starts   = 0;
  logic              rd_q       = 1'h0;
  logic              has_prev   = 1'h0;
  logic              touched    = 1'h0;
  logic              en         = 1'h1;
  channel_type       last_ch    = CH_TEMP;
  logic [23:0]       exp_q[$];

  always #20 clk = ~clk;

  power_monitor_result_scaling dut (
    .clk                (clk),
    .resetn             (resetn),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_rdata          (reg_rdata),
    .adc_start          (adc_start),
    .adc_channel        (adc_channel),
    .shunt_range_select (shunt_range_select),
    .adc_done           (adc_done),
    .adc_data           (adc_data)
  );

  converter_model conv (
    .clk         (clk),
    .resetn      (resetn),
    .adc_start   (adc_start),
    .adc_channel (adc_channel),
    .slow        (slow),
    .delta       (delta),
    .shunt_base  (shunt_base),
    .bus_base    (bus_base),
    .temp_base   (temp_base),
    .adc_done    (adc_done),
    .adc_data    (adc_data)
  );

  // ==========================================================================
  // compare and report
  task automatic cmp_read(logic [23:0] got, logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_val(logic [15:0] got, logic [15:0] exp, string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // expected results
  function automatic logic [15:0] exp_cur(logic signed [15:0] s, logic [15:0] c);
    longint p;
    p = (longint'(s) * longint'(c)) >>> 11;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction

  function automatic logic [23:0] exp_pow(logic signed [15:0] i, logic [15:0] b);
    longint a;
    a = (i < 0) ? -longint'(i) : longint'(i);
    return 24'((a * longint'(b)) >> 6);
  endfunction

  // ==========================================================================
  // output watcher
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      $display("wrong value at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  always @(posedge clk) begin
    if (rd_q && exp_q.size() > 0) cmp_read(reg_rdata, exp_q.pop_front());
    rd_q  <= reg_rd;
    since <= since + 1;
    if (adc_start === 1'h1) begin
      if (has_prev && !touched && en) begin
        cmp_val(16'(since), 16'(CONV_CYCLES - 1), "period");
        cmp_val(16'(adc_channel), 16'((last_ch == CH_TEMP) ? CH_SHUNT : last_ch + 1), "order");
      end
      n_starts <= n_starts + 1;
      since    <= 0;
      has_prev <= 1'h1;
      touched  <= 1'h0;
      last_ch  <= adc_channel;
    end
    if (reg_wr === 1'h1 && reg_addr === REG_CONFIG) begin
      touched <= 1'h1;
      en      <= reg_wdata[CFG_ENABLE_BIT];
    end
  end

  // ==========================================================================
  // bus master and sequencing
  task automatic wr(logic [3:0] a, logic [23:0] v);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(logic [3:0] a, logic [23:0] e);
    exp_q.push_back(e);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wait_start(channel_type ch);
    int i;
    for (i = 0; i < 4000; i++) begin
      @(negedge clk);
      if (adc_start === 1'h1 && adc_channel === ch) break;
    end
    if (i == 4000) cmp_val(16'h0000, 16'h0001, "no conversion start");
    @(posedge clk);
  endtask

  task automatic measure(string name, logic [4:0] cfg, logic [15:0] cal, logic [15:0] s, logic [15:0] b,
                         logic [11:0] t, int rounds, logic [15:0] d, logic sl);
    logic [15:0] be;
    logic [15:0] cur;
    shunt_base <= s;
    bus_base   <= b;
    temp_base  <= {{4{t[11]}}, t};
    delta      <= d;
    slow       <= sl;
    wr(REG_SHUNT_CAL, {8'h00, cal});
    wr(REG_CONFIG, {19'h00000, cfg});
    repeat (rounds) wait_start(CH_SHUNT);
    wait_start(CH_BUS);
    be  = b[15] ? BUS_MAX : b;
    cur = exp_cur(s, cal);
    cmp_val({15'h0000, shunt_range_select}, {15'h0000, cfg[CFG_RANGE_BIT]}, "range");
    rd(REG_CONFIG, {19'h00000, cfg});
    rd(REG_SHUNT_CAL, {8'h00, cal});
    rd(REG_SHUNT_VOLT, {8'h00, s});
    rd(REG_BUS_VOLT, {8'h00, be});
    rd(REG_DIE_TEMP, {8'h00, t, 4'h0});
    rd(REG_CURRENT, {8'h00, cur});
    rd(REG_POWER, exp_pow(cur, be));
    rd(REG_STATUS, 24'h000001);
    rd(REG_STATUS, 24'h000000);
    $display("test %s done", name);
  endtask

  initial begin
    logic [15:0] c;
    int          k;
    void'($urandom(65));
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    for (int a = 2; a < 16; a++) wr(4'(a), 24'hFFFFFF);
    for (int a = 0; a < 16; a++) rd(4'(a), (a == 0) ? {19'h00000, CONFIG_RESET} : 24'h000000);
    cmp_val({15'h0000, shunt_range_select}, 16'h0000, "range at reset");
    $display("test reset_values done");
    wait_start(CH_BUS);
    measure("zero_cal", 5'h10, 16'h0000, 16'($urandom), 16'($urandom_range(0, 32767)), 12'h123,
            2, 16'h0000, 1'h0);
    c = 16'($urandom_range(1, 65535));
    measure("positive", 5'h10, c, {1'h0, 15'($urandom)}, 16'($urandom_range(0, 32767)), 12'h0F0,
            2, 16'h0000, 1'h0);
    c = {2'h0, 14'($urandom)};
    measure("narrow_negative", 5'h11, c * 16'h0004, {1'h1, 15'($urandom)}, 16'($urandom_range(0, 32767)),
            12'h800, 2, 16'h0000, 1'h0);
    measure("clamp_saturate", 5'h10, 16'hFFFF, 16'h7FFF, 16'h9234, 12'h7FF, 2, 16'h0000, 1'h0);
    measure("average_slow", 5'h13, c, 16'hF123, 16'h2345, 12'h1F0, 8, 16'h0003, 1'h1);
    wr(REG_CONFIG, 24'h000000);
    k = n_starts;
    repeat (3000) @(posedge clk);
    cmp_val(16'(n_starts - k), 16'h0000, "starts while disabled");
    $display("test disable done");
    tally_and_finish();
  end
endmodule
